// ===== design/sync_reset_regs.vh
// Constants for the post-configuration synchronous reset generator.
// Included by the reset generator design file only; definitions only.
`ifndef SYNC_RESET_REGS_VH
`define SYNC_RESET_REGS_VH

// Pulse flip-flop states
`define PULSE_IDLE 1'b0
`define PULSE_FIRE 1'b1

// Reset pulse length in reset loops (one loop, three system clock cycles of drive)
`define PULSE_CYCLES 2'h1

`endif

// ===== design/pin_sync.v
// Two-stage synchroniser for a single asynchronous level.
// Assumes the source is unrelated to sys_clk_i; reset value is a port-free
// constant chosen by parameter.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire d_i,
  output wire q_o
);
  reg meta_r;
  reg sync_r;

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule
`default_nettype wire

// ===== design/post_config_sync_reset.v
// One-shot global reset generator aligned to the system clock, issued after
// device configuration completes. Drives an open-drain reset line that has
// an external pull-up; reads the line back to reset its own pulse flop.
// Assumes reset_line_i reads back the pad of that same line.
// Functional notes
// - Before activation user pins float with pull-up and all storage is reset.
// - Combinational enables evaluate during configuration, before activation.
// - Activation happens on a configuration clock rising edge, async to sys clk.
// - Chained devices activate on the same configuration clock edge.
// - While configuring, the low indicator sets the latch; the pulse flop is held idle.
// - After activation the latch keeps the flop input high until a clock.
// - The first system clock sets the flop and drives low; the next clears the latch.
// - The low line resets the chip and flop, then the line is released.
// - The latch is never set again while the indicator stays high.
// - The tristate control is active high: high floats, low drives.
`timescale 1ns/1ps
`default_nettype none
`include "sync_reset_regs.vh"
module post_config_sync_reset (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire config_in_progress_n_i,
  input wire configuration_clock_i,
  input wire reset_line_i,
  output reg reset_line_o,
  output reg reset_line_oe_o,
  output reg reset_line_tri_o,
  output reg chip_active_o,
  output reg global_reset_n_o
);
  wire cfg_done_s;
  wire configuration_clock_s;
  wire line_s;
  reg configuration_clock_d_r;
  reg active_r;
  reg latch_r;
  reg pulse_r;
  reg latch_nxt;
  reg pulse_nxt;
  reg active_nxt;
  reg release_nxt;
  wire configuration_clock_rise_s;

  pin_sync #(.RESET_VAL(1'b0)) u_cfg_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(config_in_progress_n_i),
    .q_o(cfg_done_s)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_configuration_clock_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(configuration_clock_i),
    .q_o(configuration_clock_s)
  );

  // Line is pulled up, so its idle synchronised value is high
  pin_sync #(.RESET_VAL(1'b1)) u_line_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(reset_line_i),
    .q_o(line_s)
  );

  // Synchronised level against its copy one cycle older
  function rise_edge;
    input now_v;
    input last_v;
    begin
      rise_edge = now_v & ~last_v;
    end
  endfunction

  // Activation waits for a configuration clock rising edge once the
  // indicator has gone high; every device sharing that clock sees it.
  function next_active;
    input cfg_done_v;
    input configuration_clock_rise_v;
    input active_v;
    begin
      if (!cfg_done_v) begin
        next_active = 1'b0;
      end else if (configuration_clock_rise_v) begin
        next_active = 1'b1;
      end else begin
        next_active = active_v;
      end
    end
  endfunction

  // Set-reset latch: the indicator sets it, the pulse flop clears it.
  // Set wins, so a pulse cannot mask a fresh configuration.
  function next_latch;
    input cfg_done_v;
    input pulse_v;
    input latch_v;
    begin
      if (!cfg_done_v) begin
        next_latch = 1'b1;
      end else if (pulse_v) begin
        next_latch = 1'b0;
      end else begin
        next_latch = latch_v;
      end
    end
  endfunction

  // Pulse flop: held idle before activation and while the line is low
  function next_pulse;
    input active_v;
    input line_v;
    input latch_v;
    input pulse_v;
    begin
      if (!active_v || !line_v) begin
        next_pulse = `PULSE_IDLE;
      end else if (latch_v) begin
        next_pulse = `PULSE_FIRE;
      end else begin
        next_pulse = pulse_v;
      end
    end
  endfunction

  // Driver enable of the open-drain reset line
  function drive_en;
    input pulse_v;
    input active_v;
    begin
      drive_en = pulse_v & active_v;
    end
  endfunction

  // Internal storage runs only once active and while the line is high
  function chip_release;
    input active_v;
    input line_v;
    begin
      chip_release = active_v & line_v;
    end
  endfunction

  assign configuration_clock_rise_s = rise_edge(configuration_clock_s, configuration_clock_d_r);

  // Latch terms are evaluated even before activation so the driver enable
  // is already defined when outputs wake up.
  always @* begin
    active_nxt = next_active(cfg_done_s, configuration_clock_rise_s, active_r);
    latch_nxt = next_latch(cfg_done_s, pulse_r, latch_r);
    pulse_nxt = next_pulse(active_r, line_s, latch_r, pulse_r);
    release_nxt = chip_release(active_nxt, line_s);
  end

  // Delayed copy resets low, the idle level of the clock, so no false edge
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      configuration_clock_d_r <= 1'b0;
    end else begin
      configuration_clock_d_r <= configuration_clock_s;
    end
  end

  // Activation is dropped only by a new configuration
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      active_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
    end
  end

  // Reset leaves the latch set so the first activation is armed
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      latch_r <= 1'b1;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // Line readback ends the pulse, so no extra clock policy is needed;
  // the loop through the pin synchroniser sets the pulse length.
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pulse_r <= `PULSE_IDLE;
    end else begin
      pulse_r <= pulse_nxt;
    end
  end

  // Open drain: data stays low and only the enable moves.
  // Tristate high floats the line, low drives it.
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reset_line_o <= 1'b0;
      reset_line_oe_o <= 1'b0;
      reset_line_tri_o <= 1'b1;
    end else begin
      reset_line_o <= 1'b0;
      reset_line_oe_o <= drive_en(pulse_nxt, active_nxt);
      reset_line_tri_o <= ~drive_en(pulse_nxt, active_nxt);
    end
  end

  // Activation status seen by the rest of the chip
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chip_active_o <= 1'b0;
    end else begin
      chip_active_o <= active_nxt;
    end
  end

  // Whole chip stays reset before activation and while line is low
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      global_reset_n_o <= 1'b0;
    end else begin
      global_reset_n_o <= release_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== tb/reset_line_model.sv
// Board reset line with an external pull-up.
// Assumes oe_i high means the block sinks the line.
`timescale 1ns/1ps
`default_nettype none
module reset_line_model (
  input wire logic oe_i,
  input wire logic d_i,
  output logic line_o
);
  assign line_o = oe_i ? d_i : 1'b1;
endmodule
`default_nettype wire

// ===== tb/post_config_sync_reset_assertions.sv
// Checker on the reset generator ports.
// Assumes a single sys_clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module post_config_sync_reset_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic reset_line_i,
  input wire logic reset_line_o,
  input wire logic reset_line_oe_o,
  input wire logic reset_line_tri_o,
  input wire logic chip_active_o,
  input wire logic global_reset_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_tri_inverse: assert property (
    reset_line_tri_o != reset_line_oe_o)
    else $error("tristate not inverse of enable");
  a_drive_low: assert property (
    reset_line_oe_o |-> !reset_line_o)
    else $error("line driven high");
  a_quiet_before: assert property (
    reset_line_oe_o |-> chip_active_o)
    else $error("pulse before activation");
  a_held_before: assert property (
    global_reset_n_o |-> chip_active_o)
    else $error("storage released before activation");
  a_pulse_starts: assert property (
    $rose(chip_active_o) |-> ##[1:3] reset_line_oe_o)
    else $error("no pulse after activation");
  a_pulse_ends: assert property (
    $rose(reset_line_oe_o) |-> ##[1:8] !reset_line_oe_o)
    else $error("pulse never ends");
  a_line_resets: assert property (
    $fell(reset_line_i) |-> ##[1:4] !global_reset_n_o)
    else $error("low line did not reset chip");
  a_single_pulse: assert property (
    $fell(reset_line_oe_o) |=> !reset_line_oe_o[*8])
    else $error("second pulse");
  cover property ($rose(chip_active_o));
  cover property ($rose(reset_line_oe_o));
  cover property ($rose(global_reset_n_o));
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Bench: config sequence, configuration_clock activation, one pulse per round.
// Assumes the board line model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 0, rst_n_i = 0, cfg_n = 0, configuration_clock = 0;
  logic line, oe, d, tri_s, act, grn;
  int bad_count = 0, checks = 0, pulses = 0, n;
  logic line2, oe2, d2, act2, grn2;
  int cq[$];
  int kq[$];
  int kd, m_act, armed, fire, ph, e_act, e_oe, e_grn, mon = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge oe) pulses++;
  reset_line_model line_u (.oe_i(oe), .d_i(d), .line_o(line));
  post_config_sync_reset dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .config_in_progress_n_i(cfg_n), .configuration_clock_i(configuration_clock),
    .reset_line_i(line), .reset_line_o(d), .reset_line_oe_o(oe),
    .reset_line_tri_o(tri_s), .chip_active_o(act), .global_reset_n_o(grn));
  reset_line_model line2_u (.oe_i(oe2), .d_i(d2), .line_o(line2));
  // Second device on the same configuration clock, as in a chain
  post_config_sync_reset dut2_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .config_in_progress_n_i(cfg_n), .configuration_clock_i(configuration_clock),
    .reset_line_i(line2), .reset_line_o(d2), .reset_line_oe_o(oe2),
    .reset_line_tri_o(), .chip_active_o(act2), .global_reset_n_o(grn2));
  // Reference model: indicator and clock seen two edges late, activation
  // one edge after the clock edge, then three cycles of drive followed by
  // three cycles of internal reset while the line recovers.
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cq = '{0, 0};
      kq = '{0, 0};
      kd = 0;
      m_act = 0;
      armed = 1;
      fire = 0;
      ph = 99;
    end else begin
      if (cq[0] == 0) begin
        m_act = 0;
        armed = 1;
        fire = 0;
        ph = 99;
      end else if (kq[0] == 1 && kd == 0 && m_act == 0) begin
        m_act = 1;
        fire = armed;
        armed = 0;
        ph = 0;
      end else if (ph < 99) begin
        ph++;
      end
      kd = kq[0];
      cq.push_back(cfg_n);
      kq.push_back(configuration_clock);
      void'(cq.pop_front());
      void'(kq.pop_front());
    end
    e_act = m_act;
    e_oe = m_act && fire && ph >= 1 && ph <= 3;
    e_grn = m_act && !(fire && ph >= 4 && ph <= 6);
    mon = 1;
  end
  always @(negedge sys_clk_i) begin
    if (mon) begin
      chk(act, e_act);
      chk(oe, e_oe);
      chk(tri_s, !e_oe);
      chk(d, 8'h00);
      chk(line, !e_oe);
      chk(grn, e_grn);
      chk(act2, act);
      chk(grn2, grn);
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wcyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  initial begin
    n = $urandom(68360);
    wcyc(16);
    rst_n_i = 1;
    for (int i = 0; i < 2; i++) begin
      cfg_n = 0;
      wcyc(8);
      if (i == 0) chk(grn, 8'h00);
      cfg_n = 1;
      wcyc(4 + $urandom % 8);
      if (i == 0) chk(act, 8'h00);
      if (i == 0) chk(tri_s, 8'h01);
      pulses = 0;
      configuration_clock = 1;
      wcyc(2 + $urandom % 4);
      configuration_clock = 0;
      n = 0;
      while (!(pulses > 0 && grn === 1 && line === 1) && n < 40) begin
        wcyc(1);
        n++;
      end
      if (n == 40) begin
        bad_count++;
        finish_test;
      end
      wcyc(30);
      chk(pulses, 8'h01);
      chk(act, 8'h01);
      chk(line, 8'h01);
      $display("round %0d done", i);
    end
    finish_test;
  end
endmodule
bind post_config_sync_reset post_config_sync_reset_assertions chk_u (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reset_line_i(reset_line_i),
  .reset_line_o(reset_line_o), .reset_line_oe_o(reset_line_oe_o),
  .reset_line_tri_o(reset_line_tri_o), .chip_active_o(chip_active_o),
  .global_reset_n_o(global_reset_n_o));
`default_nettype wire
